// ==== rtl/acs_map.vh ====
// Purpose: register map, field layout and timing constants of the conversion sequencer
// Assumes: 10 MHz core clock, 32-bit register port, byte addresses
// Notes: included by acs_top.v only
// Functional notes
// - repeat interval in delay bits 31:16
// - zero interval back to back, max longest
// - first repeat pass waits start delay
// - core enable after repeat interval expires
// - start delay in delay bits 15:0
// - core enable after start delay finishes
// - single cycle ignores both delays
// - per channel done bits, write one clears
// - single done flag after single pass
// - repeat done flag after each pass
// - single pass converts single mask channels
// - repeat pass converts repeat mask channels
// - eight per-channel result registers
// - result in low bits, upper zero
// - repeat stop finishes pass, clears timer
// - single request bit self clears on start
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_DELAY 8'h04
`define ACS_OFF_STATUS 8'h08
`define ACS_OFF_SINGLE 8'h0C
`define ACS_OFF_REPEAT 8'h10
`define ACS_OFF_RESULT0 8'h14
`define ACS_RESULT_LAST 8'h30
`define ACS_CTRL_ACTIVATE 0
`define ACS_CTRL_SINGLE 1
`define ACS_CTRL_REPEAT 2
`define ACS_CTRL_RPT_DONE 6
`define ACS_CTRL_SGL_DONE 7
`define ACS_RPT_HI 31
`define ACS_RPT_LO 16
`define ACS_START_HI 15
`define ACS_START_LO 0
`define ACS_NCH 16
`define ACS_NRES 8
`define ACS_RES_W 12
`define ACS_TICK_NS 40000
`define ACS_CLK_NS 100
`define ACS_TICK_CYC (`ACS_TICK_NS / `ACS_CLK_NS)
`define ACS_TICK_MAX 9'h18F
`define ACS_ZERO32 32'h00000000
`define ACS_ZERO16 16'h0000
`endif

// ==== rtl/acs_top.v ====
// Purpose: sequencer for a multi-channel converter: delays, channel masks, done flags, results
// Assumes: core converts one channel per conv_start pulse, returns conv_done with data
// Notes: registers reachable over a simple strobe port with read data one cycle later
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_top (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // converter core
    output reg core_en,
    output reg conv_start,
    output reg [3:0] conv_chan,
    input wire conv_done,
    input wire [11:0] conv_data
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_WAIT = 3'd1;
    localparam [2:0] ST_PICK = 3'd2;
    localparam [2:0] ST_CONV = 3'd3;
    localparam [2:0] ST_GAP = 3'd4;
    // last prescaler count, one below the 400-cycle tick period
    localparam [8:0] TICK_MAX = `ACS_TICK_MAX;

    reg [31:0] delay_q;
    reg [15:0] flags_q;
    reg [15:0] single_mask_q;
    reg [15:0] periodic_channel_mask_q;
    reg activate_q;
    reg start_single_q;
    reg start_repeat_q;
    reg sgl_done_q;
    reg rpt_done_q;
    reg [`ACS_RES_W-1:0] result_q [0:`ACS_NRES-1];
    reg [2:0] state_q;
    reg [8:0] pre_q;
    reg [15:0] wait_q;
    reg [15:0] pend_q;
    reg pass_single_q;
    reg tick;

    wire wr_ctrl = reg_wr && (reg_addr == `ACS_OFF_CTRL);
    wire [15:0] clr_flags = (reg_wr && reg_addr == `ACS_OFF_STATUS) ? reg_wdata[15:0] : `ACS_ZERO16;
    wire [15:0] done_set = (state_q == ST_CONV && conv_done) ? (16'h0001 << conv_chan) : 16'h0000;
    wire pass_end = (state_q == ST_CONV) && conv_done && ((pend_q & ~done_set) == 16'h0000);
    wire [3:0] first_ch;
    reg [3:0] first_c;
    integer i;

    // lowest pending channel is converted next
    always @* begin
        first_c = 4'h0;
        for (i = `ACS_NCH - 1; i >= 0; i = i - 1) begin
            if (pend_q[i]) begin
                first_c = i[3:0];
            end
        end
    end
    assign first_ch = first_c;

    // fixed prescaler makes one tick every 40 us; restarts at each wait so the first tick is full
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_q <= 9'h000;
            tick <= 1'b0;
        end else if (state_q != ST_WAIT && state_q != ST_GAP) begin
            pre_q <= 9'h000;
            tick <= 1'b0;
        end else if (pre_q == TICK_MAX) begin
            pre_q <= 9'h000;
            tick <= 1'b1;
        end else begin
            pre_q <= pre_q + 9'h001;
            tick <= 1'b0;
        end
    end

    // software registers; hardware sets win over software clears
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            delay_q <= `ACS_ZERO32;
            single_mask_q <= `ACS_ZERO16;
            periodic_channel_mask_q <= `ACS_ZERO16;
            activate_q <= 1'b0;
            start_single_q <= 1'b0;
            start_repeat_q <= 1'b0;
            sgl_done_q <= 1'b0;
            rpt_done_q <= 1'b0;
            flags_q <= `ACS_ZERO16;
        end else begin
            if (reg_wr && reg_addr == `ACS_OFF_DELAY) begin
                delay_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ACS_OFF_SINGLE) begin
                single_mask_q <= reg_wdata[15:0];
            end
            if (reg_wr && reg_addr == `ACS_OFF_REPEAT) begin
                periodic_channel_mask_q <= reg_wdata[15:0];
            end
            if (wr_ctrl) begin
                activate_q <= reg_wdata[`ACS_CTRL_ACTIVATE];
                start_repeat_q <= reg_wdata[`ACS_CTRL_REPEAT];
            end
            if (wr_ctrl && reg_wdata[`ACS_CTRL_SINGLE]) begin
                start_single_q <= 1'b1;
            end else if (state_q == ST_IDLE && start_single_q && activate_q) begin
                start_single_q <= 1'b0;
            end
            flags_q <= (flags_q & ~clr_flags) | done_set;
            if (pass_end && pass_single_q) begin
                sgl_done_q <= 1'b1;
            end else if (wr_ctrl && reg_wdata[`ACS_CTRL_SGL_DONE]) begin
                sgl_done_q <= 1'b0;
            end
            if (pass_end && !pass_single_q) begin
                rpt_done_q <= 1'b1;
            end else if (wr_ctrl && reg_wdata[`ACS_CTRL_RPT_DONE]) begin
                rpt_done_q <= 1'b0;
            end
        end
    end

    // sequencer: wait, then walk the enabled channels one at a time
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            wait_q <= `ACS_ZERO16;
            pend_q <= `ACS_ZERO16;
            pass_single_q <= 1'b0;
            core_en <= 1'b0;
            conv_start <= 1'b0;
            conv_chan <= 4'h0;
        end else begin
            conv_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    core_en <= 1'b0;
                    if (activate_q && start_single_q) begin
                        pend_q <= single_mask_q;
                        pass_single_q <= 1'b1;
                        state_q <= ST_PICK;
                    end else if (activate_q && start_repeat_q) begin
                        wait_q <= delay_q[`ACS_START_HI:`ACS_START_LO];
                        pass_single_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT, ST_GAP: begin
                    core_en <= 1'b0;
                    if (!start_repeat_q || !activate_q) begin
                        wait_q <= `ACS_ZERO16;
                        state_q <= ST_IDLE;
                    end else if (wait_q == `ACS_ZERO16) begin
                        pend_q <= periodic_channel_mask_q;
                        state_q <= ST_PICK;
                    end else if (tick) begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                ST_PICK: begin
                    core_en <= 1'b1;
                    if (pend_q == `ACS_ZERO16) begin
                        state_q <= pass_single_q ? ST_IDLE : ST_GAP;
                        wait_q <= delay_q[`ACS_RPT_HI:`ACS_RPT_LO];
                    end else begin
                        conv_chan <= first_ch;
                        conv_start <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        pend_q <= pend_q & ~done_set;
                        state_q <= ST_PICK; // a running pass always finishes
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // result capture for the eight channels that own a reading register
    genvar g;
    generate
        for (g = 0; g < `ACS_NRES; g = g + 1) begin : g_res
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    result_q[g] <= 12'h000;
                end else if (done_set[g]) begin
                    result_q[g] <= conv_data;
                end
            end
        end
    endgenerate

    // read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `ACS_ZERO32;
        end else if (!reg_rd) begin
            reg_rdata <= `ACS_ZERO32;
        end else if (reg_addr == `ACS_OFF_CTRL) begin
            reg_rdata <= {24'h000000, sgl_done_q, rpt_done_q, 3'h0, start_repeat_q,
                          start_single_q, activate_q};
        end else if (reg_addr == `ACS_OFF_DELAY) begin
            reg_rdata <= delay_q;
        end else if (reg_addr == `ACS_OFF_STATUS) begin
            reg_rdata <= {16'h0000, flags_q};
        end else if (reg_addr == `ACS_OFF_SINGLE) begin
            reg_rdata <= {16'h0000, single_mask_q};
        end else if (reg_addr == `ACS_OFF_REPEAT) begin
            reg_rdata <= {16'h0000, periodic_channel_mask_q};
        end else if (reg_addr >= `ACS_OFF_RESULT0 && reg_addr <= `ACS_RESULT_LAST
                     && reg_addr[1:0] == 2'b00) begin
            reg_rdata <= {20'h00000, result_q[reg_addr[4:2] - 3'd5]};
        end else begin
            reg_rdata <= `ACS_ZERO32;
        end
    end
endmodule // acs_top
`default_nettype wire

// ==== test/acs_props.sv ====
// Purpose: checker of register answers and core handshake
// Assumes: sees acs_top ports only
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module acs_props (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // converter core
    input wire core_en,
    input wire conv_start,
    input wire [3:0] conv_chan,
    input wire conv_done,
    input wire [11:0] conv_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // read of a result word, answered next cycle
    sequence s_rd_res;
        reg_rd && reg_addr >= 8'h14 && reg_addr <= 8'h30;
    endsequence
    // start is a lone pulse
    sequence s_pulse;
        conv_start ##1 !conv_start;
    endsequence
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data not zero outside answer");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h30 |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_RES_UPPER: assert property (s_rd_res |=> reg_rdata[31:12] == 20'h00000)
        else $error("result upper bits set");
    AST_STAT_UPPER: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[31:16] == 16'h0000)
        else $error("status upper bits set");
    AST_START_PULSE: assert property (conv_start |-> s_pulse)
        else $error("start longer than one cycle");
    AST_START_EN: assert property (conv_start |-> core_en)
        else $error("start without core enable");
    AST_CHAN_HOLD: assert property (!conv_start |-> $stable(conv_chan))
        else $error("channel moved mid conversion");
    AST_EN_RISE: assert property ($rose(core_en) |-> conv_start)
        else $error("enable rose without start");
endmodule // acs_props
bind acs_top acs_props acs_props_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_en, .conv_start, .conv_chan, .conv_done, .conv_data);
`default_nettype wire

// ==== test/acs_core_model.sv ====
// Purpose: behavioural converter core
// Assumes: one start pulse per channel
// Notes: answers four cycles after start; data toggles when idle
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // sequencer side
    input wire conv_start,
    input wire [3:0] conv_chan,
    output logic conv_done,
    output logic [11:0] conv_data
);
    logic [1:0] cnt_q;
    // result is channel and a fixed pattern; idle data inverts so stale values never match
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            cnt_q <= conv_start ? 2'h3 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
            conv_done <= (cnt_q == 2'h1);
            conv_data <= (cnt_q == 2'h1) ? {conv_chan, 8'h5A} : ~conv_data;
        end
    end
endmodule // acs_core_model
`default_nettype wire

// ==== test/tb_acs_top.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: 10 MHz clock, tick of 400 cycles
// Notes: delays kept to a few ticks to keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb_acs_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire core_en, conv_start, conv_done;
    wire [3:0] conv_chan;
    wire [11:0] conv_data;
    int fail_count = 0;
    int check_count = 0;
    int n;
    logic [31:0] rd_q;
    always #50 core_clk = ~core_clk;
    acs_top acs_top_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .core_en, .conv_start, .conv_chan, .conv_done, .conv_data);
    acs_core_model acs_core_model_i (.core_clk, .rst, .conv_start, .conv_chan, .conv_done,
        .conv_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // one-cycle strobes, set right after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    // bounded wait on the core enable level
    task automatic wait_en(input logic v, output int c);
        c = 0;
        while (core_en !== v && c < 3000) begin
            @(posedge core_clk);
            #1 c++;
        end
    endtask
    task automatic t_regs();
        for (int i = 1; i < 5; i++) begin
            rd(8'(4 * i));
            chk(rd_q, 32'h00000000);
        end
        rd(8'h40);
        chk(rd_q, 32'h00000000);
        wr(8'h04, 32'hFFFF0010);
        rd(8'h04);
        chk(rd_q, 32'hFFFF0010);
        wr(8'h04, 32'h00100000);
        rd(8'h04);
        chk(rd_q, 32'h00100000);
        $display("t_regs done");
    endtask
    task automatic t_single();
        wr(8'h0C, 32'h00000005);
        wr(8'h04, 32'h00020003);
        wr(8'h00, 32'h00000003); // mask left alone while the pass runs
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, conv_start}, 32'h00000001);
        wait_en(1'b0, n);
        rd(8'h08);
        chk(rd_q, 32'h00000005);
        rd(8'h00);
        chk(rd_q & 32'h00000087, 32'h00000081);
        rd(8'h14); // one full-word read of the result
        chk(rd_q, 32'h0000005A);
        rd(8'h1C);
        chk(rd_q, 32'h0000025A);
        wr(8'h08, 32'h00000001);
        rd(8'h08);
        chk(rd_q, 32'h00000004);
        wr(8'h08, 32'h00000004);
        $display("t_single done");
    endtask
    task automatic t_repeat();
        wr(8'h10, 32'h00000002);
        wr(8'h00, 32'h00000005);
        wait_en(1'b1, n);
        chk({31'h0, n >= 1195 && n <= 1205}, 32'h00000001);
        wait_en(1'b0, n);
        wait_en(1'b1, n);
        chk({31'h0, n >= 795 && n <= 805}, 32'h00000001);
        rd(8'h08);
        chk(rd_q, 32'h00000002);
        rd(8'h00);
        chk(rd_q & 32'h00000044, 32'h00000044);
        wait_en(1'b0, n);
        wr(8'h00, 32'h00000001);
        wait_en(1'b1, n);
        chk(n, 32'd3000);
        $display("t_repeat done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog: about four times the expected run
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_single();
        t_repeat();
        finish_test();
    end
endmodule // tb_acs_top
`default_nettype wire
